// ===== hdl/eeprom_port_config_loader.sv
`timescale 1ns/100ps
module eeprom_port_config_loader
    import eeprom_loader_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // eeprom word reader
    input wire logic ee_present,
    output logic ee_rd_req,
    output logic [7:0] ee_rd_addr,
    input wire logic ee_rd_ack,
    input wire logic ee_rd_err,
    input wire logic [15:0] ee_rd_data,
    // loader state
    output logic cfg_ready,
    // ports 0 and 1 (index 0 = port 0)
    output logic [1:0] port_disable,
    output logic [1:0] port_reset_sel,
    output logic [1:0] clock_pm_cap,
    output logic [1:0] pcipm_substate11_support,
    output logic [1:0] aspm_substate11_support,
    output logic [1:0] pm_substates_support,
    output logic [1:0] vc_arbitration_select,
    output logic [1:0] grant_fail_mode,
    // ports 2 and 3 (index 0 = port 2)
    output logic [1:0] slot_implemented,
    output logic [1:0] slot_clock_cfg,
    output logic [1:0] dsi_required,
    output logic [1:0] low_priority_vc_group,
    output logic [1:0][2:0] logical_port_num,
    output logic [1:0][6:0] vc0_tc_map
);

    // word stores
    word_port_if wp [NUM_PORTS] ();
    logic [NUM_PORTS-1:0] load_vec;
    logic [NUM_PORTS-1:0] loaded_vec;
    logic [NUM_PORTS-1:0][15:0] word_vec;
    logic [15:0] store_wdata;
    logic restore_all;

    // loader state
    load_state_e state_reg;
    logic [1:0] settle_cnt_reg;
    logic [1:0] fetch_idx_reg;
    logic present_meta_reg;
    logic present_sync_reg;
    logic err_reg;
    logic busy;
    logic ee_word_ok;

    // bus state
    logic pend_reg;
    logic pend_write_reg;
    logic [ADDR_W-1:0] pend_addr_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic accept;
    logic complete;
    logic write_fire;
    logic reload_start;
    logic word_hit;
    logic [1:0] word_sel;
    logic [31:0] read_mux;

    // output flops
    logic ee_rd_req_reg;
    logic [7:0] ee_rd_addr_reg;
    logic cfg_ready_reg;
    logic [1:0] port_disable_reg;
    logic [1:0] port_reset_sel_reg;
    logic [1:0] clock_pm_cap_reg;
    logic [1:0] pcipm_l11_reg;
    logic [1:0] aspm_l11_reg;
    logic [1:0] substates_reg;
    logic [1:0] arb_sel_reg;
    logic [1:0] gnt_fail_reg;
    logic [1:0] slot_impl_reg;
    logic [1:0] slot_clk_reg;
    logic [1:0] dsi_reg;
    logic [1:0] low_priority_vc_group_reg;
    logic [1:0][2:0] port_num_reg;
    logic [1:0][6:0] tc_map_reg;

    function automatic logic [7:0] ee_word_addr(input logic [1:0] idx);
        logic [7:0] a;
        a = EE_ADDR_PORT0;
        unique case (idx)
            2'h0: a = EE_ADDR_PORT0;
            2'h1: a = EE_ADDR_PORT1;
            2'h2: a = EE_ADDR_PORT2;
            2'h3: a = EE_ADDR_PORT3;
        endcase
        return a;
    endfunction

    // word stores, tl for ports 0,1 and slot for ports 2,3
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_store
            localparam logic [15:0] DEF =
                (g < 2) ? TL_WORD_DEFAULT : SLOT_WORD_DEFAULT;
            cfg_word_store #(
                .DEFAULT_WORD(DEF)
            ) u_store (
                .hclk(hclk),
                .hresetn(hresetn),
                .wp(wp[g])
            );
            assign wp[g].load = load_vec[g];
            assign wp[g].restore = restore_all;
            assign wp[g].wdata = store_wdata;
            assign word_vec[g] = wp[g].word;
            assign loaded_vec[g] = wp[g].loaded;
        end
    endgenerate

    // presence pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            present_meta_reg <= 1'b0;
            present_sync_reg <= 1'b0;
        end else begin
            present_meta_reg <= ee_present;
            present_sync_reg <= present_meta_reg;
        end
    end

    assign busy = (state_reg != LD_DONE);
    assign ee_word_ok = (state_reg == LD_WAIT) && ee_rd_ack && !ee_rd_err;
    assign restore_all = reload_start;

    // word load strobes from eeprom or software
    always_comb begin
        load_vec = '0;
        store_wdata = ee_rd_data;
        if (ee_word_ok) begin
            load_vec[fetch_idx_reg] = 1'b1;
        end else if (write_fire && word_hit) begin
            load_vec[word_sel] = 1'b1;
            store_wdata = hwdata[15:0];
        end
    end

    // loader sequence after reset and on reload
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= LD_SETTLE;
            settle_cnt_reg <= 2'h0;
            fetch_idx_reg <= 2'h0;
            ee_rd_req_reg <= 1'b0;
            ee_rd_addr_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                LD_SETTLE: begin
                    settle_cnt_reg <= settle_cnt_reg + 2'h1;
                    if (settle_cnt_reg == SYNC_SETTLE) begin
                        settle_cnt_reg <= 2'h0;
                        fetch_idx_reg <= 2'h0;
                        state_reg <= present_sync_reg ? LD_REQ : LD_DONE;
                    end
                end
                LD_REQ: begin
                    ee_rd_req_reg <= 1'b1;
                    ee_rd_addr_reg <= ee_word_addr(fetch_idx_reg);
                    state_reg <= LD_WAIT;
                end
                LD_WAIT: begin
                    if (ee_rd_ack) begin
                        ee_rd_req_reg <= 1'b0;
                        fetch_idx_reg <= fetch_idx_reg + 2'h1;
                        if (fetch_idx_reg == 2'h3) begin
                            state_reg <= LD_DONE;
                        end else begin
                            state_reg <= LD_REQ;
                        end
                    end
                end
                LD_DONE: begin
                    if (reload_start) begin
                        state_reg <= LD_SETTLE;
                    end
                end
            endcase
        end
    end

    // sticky read error, set wins over reload clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_reg <= 1'b0;
        end else if ((state_reg == LD_WAIT) && ee_rd_ack && ee_rd_err) begin
            err_reg <= 1'b1;
        end else if (reload_start) begin
            err_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ready_reg <= 1'b0;
        end else begin
            cfg_ready_reg <= !busy && !reload_start;
        end
    end

    // ahb-lite slave, held in wait while loading
    assign accept = hsel && htrans[1] && hready;
    assign complete = pend_reg && cfg_ready_reg;
    assign write_fire = complete && pend_write_reg;
    assign reload_start = write_fire && (pend_addr_reg == CTRL_OFS) &&
                          hwdata[CTRL_RELOAD_BIT];
    assign word_hit = (pend_addr_reg[ADDR_W-1:4] == WORD_BASE_OFS[7:4]) &&
                      (pend_addr_reg[1:0] == 2'h0);
    assign word_sel = pend_addr_reg[3:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg <= 1'b0;
            pend_write_reg <= 1'b0;
            pend_addr_reg <= '0;
            hreadyout_reg <= 1'b1;
        end else if (accept) begin
            pend_reg <= 1'b1;
            pend_write_reg <= hwrite;
            pend_addr_reg <= haddr[ADDR_W-1:0];
            hreadyout_reg <= 1'b0;
        end else if (complete) begin
            pend_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
        end
    end

    always_comb begin
        read_mux = 32'h0000_0000;
        if (pend_addr_reg == STATUS_OFS) begin
            read_mux[STATUS_BUSY_BIT] = busy;
            read_mux[STATUS_DONE_BIT] = cfg_ready_reg;
            read_mux[STATUS_PRESENT_BIT] = present_sync_reg;
            read_mux[STATUS_ERR_BIT] = err_reg;
        end else if (word_hit) begin
            read_mux[15:0] = word_vec[word_sel];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (complete && !pend_write_reg) begin
            hrdata_reg <= read_mux;
        end
    end

    // transaction-layer fields, ports 0 and 1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_disable_reg <= {2{TL_WORD_DEFAULT[PORT_DIS_BIT]}};
            port_reset_sel_reg <= {2{TL_WORD_DEFAULT[RST_SEL_BIT]}};
            clock_pm_cap_reg <= {2{TL_WORD_DEFAULT[CLK_PM_BIT]}};
            pcipm_l11_reg <= {2{TL_WORD_DEFAULT[PCIPM_L11_BIT]}};
            aspm_l11_reg <= {2{TL_WORD_DEFAULT[ASPM_L11_BIT]}};
            substates_reg <= {2{TL_WORD_DEFAULT[SUBST_BIT]}};
            arb_sel_reg <= {2{TL_WORD_DEFAULT[ARB_SEL_BIT]}};
            gnt_fail_reg <= {2{TL_WORD_DEFAULT[GNT_FAIL_BIT]}};
        end else begin
            for (int p = 0; p < 2; p++) begin
                port_disable_reg[p] <= word_vec[p][PORT_DIS_BIT];
                port_reset_sel_reg[p] <= word_vec[p][RST_SEL_BIT];
                clock_pm_cap_reg[p] <= word_vec[p][CLK_PM_BIT];
                pcipm_l11_reg[p] <= word_vec[p][PCIPM_L11_BIT];
                aspm_l11_reg[p] <= word_vec[p][ASPM_L11_BIT];
                substates_reg[p] <= word_vec[p][SUBST_BIT];
                arb_sel_reg[p] <= word_vec[p][ARB_SEL_BIT];
                gnt_fail_reg[p] <= word_vec[p][GNT_FAIL_BIT];
            end
        end
    end

    // slot fields, ports 2 and 3
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_impl_reg <= {2{SLOT_WORD_DEFAULT[SLOT_IMPL_BIT]}};
            slot_clk_reg <= {2{SLOT_WORD_DEFAULT[SLOT_CLK_BIT]}};
            dsi_reg <= {2{SLOT_WORD_DEFAULT[DSI_BIT]}};
            low_priority_vc_group_reg <= {2{SLOT_WORD_DEFAULT[LOW_PRIORITY_VC_GROUP_BIT]}};
            port_num_reg <= {2{SLOT_WORD_DEFAULT[PORT_NUM_MSB:PORT_NUM_LSB]}};
            tc_map_reg <= {2{TC_MAP_DEFAULT}};
        end else begin
            for (int p = 0; p < 2; p++) begin
                slot_impl_reg[p] <= word_vec[p+2][SLOT_IMPL_BIT];
                slot_clk_reg[p] <= word_vec[p+2][SLOT_CLK_BIT];
                dsi_reg[p] <= word_vec[p+2][DSI_BIT];
                low_priority_vc_group_reg[p] <= word_vec[p+2][LOW_PRIORITY_VC_GROUP_BIT];
                port_num_reg[p] <=
                    word_vec[p+2][PORT_NUM_MSB:PORT_NUM_LSB];
                if (loaded_vec[p+2]) begin
                    tc_map_reg[p] <=
                        word_vec[p+2][TC_MAP_MSB:TC_MAP_LSB];
                end else begin
                    tc_map_reg[p] <= TC_MAP_DEFAULT;
                end
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign ee_rd_req = ee_rd_req_reg;
    assign ee_rd_addr = ee_rd_addr_reg;
    assign cfg_ready = cfg_ready_reg;
    assign port_disable = port_disable_reg;
    assign port_reset_sel = port_reset_sel_reg;
    assign clock_pm_cap = clock_pm_cap_reg;
    assign pcipm_substate11_support = pcipm_l11_reg;
    assign aspm_substate11_support = aspm_l11_reg;
    assign pm_substates_support = substates_reg;
    assign vc_arbitration_select = arb_sel_reg;
    assign grant_fail_mode = gnt_fail_reg;
    assign slot_implemented = slot_impl_reg;
    assign slot_clock_cfg = slot_clk_reg;
    assign dsi_required = dsi_reg;
    assign low_priority_vc_group = low_priority_vc_group_reg;
    assign logical_port_num = port_num_reg;
    assign vc0_tc_map = tc_map_reg;

endmodule // eeprom_port_config_loader

// ===== hdl/eeprom_loader_pkg.sv
package eeprom_loader_pkg;

    // ports 0..3 of the switch
    localparam int NUM_PORTS = 4;

    // eeprom word addresses per port
    localparam logic [7:0] EE_ADDR_PORT0 = 8'h68;
    localparam logic [7:0] EE_ADDR_PORT1 = 8'h6a;
    localparam logic [7:0] EE_ADDR_PORT2 = 8'h64;
    localparam logic [7:0] EE_ADDR_PORT3 = 8'h66;

    // word defaults
    localparam logic [15:0] TL_WORD_DEFAULT = 16'h0050;
    localparam logic [15:0] SLOT_WORD_DEFAULT = 16'h0022;
    localparam logic [6:0] TC_MAP_DEFAULT = 7'h7f;

    // slot-configuration word fields
    localparam int SLOT_IMPL_BIT = 0;
    localparam int SLOT_CLK_BIT = 1;
    localparam int DSI_BIT = 2;
    localparam int LOW_PRIORITY_VC_GROUP_BIT = 3;
    localparam int PORT_NUM_LSB = 4;
    localparam int PORT_NUM_MSB = 6;
    localparam int TC_MAP_LSB = 9;
    localparam int TC_MAP_MSB = 15;

    // transaction-layer word fields
    localparam int PORT_DIS_BIT = 0;
    localparam int RST_SEL_BIT = 1;
    localparam int CLK_PM_BIT = 2;
    localparam int PCIPM_L11_BIT = 4;
    localparam int ASPM_L11_BIT = 5;
    localparam int SUBST_BIT = 6;
    localparam int ARB_SEL_BIT = 8;
    localparam int GNT_FAIL_BIT = 9;

    // bus register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] WORD_BASE_OFS = 8'h10;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DONE_BIT = 1;
    localparam int STATUS_PRESENT_BIT = 2;
    localparam int STATUS_ERR_BIT = 3;

    // cycles for the presence synchroniser to settle
    localparam logic [1:0] SYNC_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        LD_SETTLE,
        LD_REQ,
        LD_WAIT,
        LD_DONE
    } load_state_e;

endpackage

// ===== hdl/word_port_if.sv
`timescale 1ns/100ps
interface word_port_if;
    logic load;
    logic restore;
    logic [15:0] wdata;
    logic [15:0] word;
    logic loaded;
    modport store(input load, input restore, input wdata,
                  output word, output loaded);
    modport ctrl(output load, output restore, output wdata,
                 input word, input loaded);
endinterface

// ===== hdl/cfg_word_store.sv
`timescale 1ns/100ps
module cfg_word_store
    import eeprom_loader_pkg::*;
#(
    parameter logic [15:0] DEFAULT_WORD = 16'h0000
) (
    input wire logic hclk,
    input wire logic hresetn,
    word_port_if.store wp
);

    logic [15:0] word_reg;
    logic loaded_reg;

    // one configuration word, default until loaded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_reg <= DEFAULT_WORD;
            loaded_reg <= 1'b0;
        end else if (wp.load) begin
            word_reg <= wp.wdata;
            loaded_reg <= 1'b1;
        end else if (wp.restore) begin
            word_reg <= DEFAULT_WORD;
            loaded_reg <= 1'b0;
        end
    end

    assign wp.word = word_reg;
    assign wp.loaded = loaded_reg;

endmodule // cfg_word_store

// ===== dv/eeprom_port_config_loader_props.sv
`timescale 1ns/100ps
module eeprom_port_config_loader_props
    import eeprom_loader_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic ee_rd_req,
    input wire logic [7:0] ee_rd_addr,
    input wire logic ee_rd_ack,
    input wire logic ee_rd_err,
    input wire logic [15:0] ee_rd_data,
    input wire logic cfg_ready,
    input wire logic [1:0] port_disable,
    input wire logic [1:0] port_reset_sel,
    input wire logic [1:0] clock_pm_cap,
    input wire logic [1:0] pcipm_substate11_support,
    input wire logic [1:0] aspm_substate11_support,
    input wire logic [1:0] pm_substates_support,
    input wire logic [1:0] vc_arbitration_select,
    input wire logic [1:0] grant_fail_mode,
    input wire logic [1:0] slot_implemented,
    input wire logic [1:0] slot_clock_cfg,
    input wire logic [1:0] dsi_required,
    input wire logic [1:0] low_priority_vc_group,
    input wire logic [1:0][2:0] logical_port_num,
    input wire logic [1:0][6:0] vc0_tc_map
);
    logic [15:0] wq;
    logic taken;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    assign taken = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wq <= 16'h0;
        end else if (ee_rd_ack) begin
            wq <= ee_rd_data;
        end
    end
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("hresp not okay");
    property p_hold;
        ee_rd_req && !ee_rd_ack |=> ee_rd_req && $stable(ee_rd_addr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("word request dropped early");
    property p_gap;
        ee_rd_ack |=> !ee_rd_req;
    endproperty
    a_gap: assert property (p_gap)
        else $error("no gap after word");
    property p_order;
        ee_rd_ack && ee_rd_addr == EE_ADDR_PORT0 |->
            ##2 ee_rd_req && ee_rd_addr == EE_ADDR_PORT1;
    endproperty
    a_order: assert property (p_order)
        else $error("word order wrong");
    property p_tl0;
        ee_rd_ack && !ee_rd_err && ee_rd_addr == EE_ADDR_PORT0 |-> ##3
        {grant_fail_mode[0], vc_arbitration_select[0],
        pm_substates_support[0], aspm_substate11_support[0],
        pcipm_substate11_support[0], clock_pm_cap[0], port_reset_sel[0],
        port_disable[0]} == {wq[9:8], wq[6:4], wq[2:0]};
    endproperty
    a_tl0: assert property (p_tl0)
        else $error("port 0 fields wrong");
    property p_slot2;
        ee_rd_ack && !ee_rd_err && ee_rd_addr == EE_ADDR_PORT2 |-> ##3
        {vc0_tc_map[0], logical_port_num[0], low_priority_vc_group[0],
        dsi_required[0], slot_clock_cfg[0], slot_implemented[0]} ==
        {wq[15:9], wq[6:0]};
    endproperty
    a_slot2: assert property (p_slot2)
        else $error("port 2 fields wrong");
    property p_stall;
        !cfg_ready && (taken || !hreadyout) |=> !hreadyout;
    endproperty
    a_stall: assert property (p_stall)
        else $error("bus answered while loading");
    property p_wait;
        cfg_ready && taken |=> !hreadyout ##1 hreadyout;
    endproperty
    a_wait: assert property (p_wait)
        else $error("idle wait state wrong");
endmodule // eeprom_port_config_loader_props
bind eeprom_port_config_loader eeprom_port_config_loader_props i_props (
    .hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hresp,
    .ee_rd_req, .ee_rd_addr, .ee_rd_ack, .ee_rd_err, .ee_rd_data,
    .cfg_ready, .port_disable, .port_reset_sel, .clock_pm_cap,
    .pcipm_substate11_support, .aspm_substate11_support,
    .pm_substates_support, .vc_arbitration_select, .grant_fail_mode,
    .slot_implemented, .slot_clock_cfg, .dsi_required,
    .low_priority_vc_group, .logical_port_num, .vc0_tc_map
);

// ===== dv/ee_reader_model.sv
`timescale 1ns/100ps
module ee_reader_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ee_rd_req,
    input wire logic [7:0] ee_rd_addr,
    input wire logic [3:0] lat,
    input wire logic [3:0] err_mask,
    input wire logic [63:0] words,
    output logic ee_rd_ack,
    output logic ee_rd_err,
    output logic [15:0] ee_rd_data
);
    logic [3:0] cnt;
    logic [1:0] idx;
    assign idx = ee_rd_addr[2:1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 4'h0;
            ee_rd_ack <= 1'b0;
            ee_rd_err <= 1'b0;
            ee_rd_data <= 16'h5a5a;
        end else if (ee_rd_req && !ee_rd_ack && cnt == lat) begin
            cnt <= 4'h0;
            ee_rd_ack <= 1'b1;
            ee_rd_err <= err_mask[idx];
            ee_rd_data <= words[idx*16 +: 16];
        end else begin
            cnt <= (ee_rd_req && !ee_rd_ack) ? cnt + 4'h1 : 4'h0;
            ee_rd_ack <= 1'b0;
            ee_rd_err <= ~ee_rd_err;
            ee_rd_data <= ~ee_rd_data;
        end
    end
endmodule // ee_reader_model

// ===== dv/eeprom_port_config_loader_tb.sv
`timescale 1ns/100ps
module eeprom_port_config_loader_tb
    import eeprom_loader_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cfg_ready;
    logic ee_present, ee_rd_req, ee_rd_ack, ee_rd_err;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans, port_disable, port_reset_sel, clock_pm_cap;
    logic [1:0] pcipm_substate11_support, aspm_substate11_support;
    logic [1:0] pm_substates_support, grant_fail_mode, slot_implemented;
    logic [1:0] slot_clock_cfg, dsi_required, low_priority_vc_group;
    logic [1:0] vc_arbitration_select;
    logic [1:0][2:0] logical_port_num;
    logic [1:0][6:0] vc0_tc_map;
    logic [7:0] ee_rd_addr;
    logic [15:0] ee_rd_data;
    logic [3:0] lat, err_mask, ld, em;
    logic [63:0] words;
    logic [15:0] w [4];
    logic [31:0] exp_q [$];
    logic rd_ph = 1'b0;
    int seed = 32'h99f2;
    int err_count = 0;
    int n_checks = 0;
    eeprom_port_config_loader i_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .ee_present, .ee_rd_req, .ee_rd_addr, .ee_rd_ack, .ee_rd_err,
        .ee_rd_data, .cfg_ready, .port_disable, .port_reset_sel,
        .clock_pm_cap, .pcipm_substate11_support, .aspm_substate11_support,
        .pm_substates_support, .vc_arbitration_select, .grant_fail_mode,
        .slot_implemented, .slot_clock_cfg, .dsi_required,
        .low_priority_vc_group, .logical_port_num, .vc0_tc_map
    );
    ee_reader_model i_ee (
        .hclk, .hresetn, .ee_rd_req, .ee_rd_addr, .lat, .err_mask, .words,
        .ee_rd_ack, .ee_rd_err, .ee_rd_data
    );
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic wr,
                        input logic [31:0] d);
        int n;
        n = 0;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1);
    endtask
    task automatic ahb_rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(a, 1'b0, ~e);
    endtask
    task automatic pick(input logic [3:0] m);
        logic [31:0] v;
        logic [63:0] nw;
        for (int p = 0; p < 4; p++) begin
            v = $random(seed);
            nw[p*16 +: 16] = v[15:0];
            w[p] = m[p] ? (p < 2 ? 16'h0050 : 16'h0022) : v[15:0];
            ld[p] = ~m[p];
        end
        v = $random(seed);
        words <= nw;
        lat <= v[3:0];
        err_mask <= m;
    endtask
    task automatic check_outs;
        for (int p = 0; p < 2; p++) begin
            check({24'h0, grant_fail_mode[p], vc_arbitration_select[p],
                pm_substates_support[p], aspm_substate11_support[p],
                pcipm_substate11_support[p], clock_pm_cap[p],
                port_reset_sel[p], port_disable[p]},
                {24'h0, w[p][9:8], w[p][6:4], w[p][2:0]});
            check({18'h0, vc0_tc_map[p], logical_port_num[p],
                low_priority_vc_group[p], dsi_required[p],
                slot_clock_cfg[p], slot_implemented[p]},
                {18'h0, (ld[p+2] ? w[p+2][15:9] : 7'h7f),
                w[p+2][6:0]});
        end
        for (int p = 0; p < 4; p++)
            ahb_rd(WORD_BASE_OFS + 8'(4 * p), {16'h0, w[p]});
    endtask
    task automatic do_reset(input logic pres);
        hresetn <= 1'b0;
        ee_present <= pres;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1)
            check(hrdata, exp_q.pop_front());
        if (hreadyout === 1'b1)
            rd_ph <= hsel && htrans[1] && !hwrite;
    end
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        stop_test;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ee_present = 1'b1;
        pick(4'h0);
        do_reset(1'b1);
        ahb_rd(STATUS_OFS, 32'h6);
        repeat (4) @(posedge hclk);
        check_outs;
        for (int i = 0; i < 8; i++) begin
            em = 4'($random(seed));
            pick(em);
            xfer(CTRL_OFS, 1'b1, 32'h1);
            repeat (3) @(posedge hclk);
            ahb_rd(STATUS_OFS, {28'h0, |em, 3'h6});
            repeat (4) @(posedge hclk);
            check_outs;
        end
        pick(4'hf);
        err_mask <= 4'h0;
        do_reset(1'b0);
        ahb_rd(STATUS_OFS, 32'h2);
        repeat (4) @(posedge hclk);
        check_outs;
        r = $random(seed);
        xfer(WORD_BASE_OFS + 8'hc, 1'b1, r);
        xfer(WORD_BASE_OFS, 1'b1, ~r);
        w[3] = r[15:0];
        w[0] = ~r[15:0];
        ld = 4'h9;
        repeat (3) @(posedge hclk);
        check_outs;
        xfer(8'h40, 1'b1, r);
        xfer(STATUS_OFS, 1'b1, 32'hf);
        ahb_rd(8'h40, 32'h0);
        ahb_rd(STATUS_OFS, 32'h2);
        repeat (3) @(posedge hclk);
        stop_test;
    end
endmodule // eeprom_port_config_loader_tb
